// >>> pcps_phase_engine.sv
// Device-side phase engine for packet commands on the task file
//
// Contract
// [RULE1] Awaiting packet: command-or-data one, direction zero, release zero.
// [RULE2] Awaiting packet: byte count registers show the host's limit.
// [RULE3] Awaiting packet: busy clear, data request set, DMA ready and check clear.
// [RULE4] Service flag set whenever another queued command is ready.
// [RULE5] Tag field carries command tag only with queuing and overlap enabled.
// [RULE6] Data moves only after the packet; overlap may defer it to service.
// [RULE7] PIO data request presents the byte count for that request.
// [RULE8] Presented count never zero and never above the host limit; a limit of 1 with more to move presents 2; an even remainder then ends on a count of 0.
// [RULE9] Presented count never above FFFEh.
// [RULE10] Counts even except the last; a padded last count is odd.
// [RULE11] Odd count: last byte on low lines, upper byte is discarded pad.
// [RULE12] Data phase: command-or-data and release clear, direction per transfer.
// [RULE13] Data phase: busy clear, request set, check clear, DMA ready if overlapped DMA.
// [RULE14] Packet fully taken: busy set, data request cleared.
// [RULE15] Overlapped data command not ready may release the bus.
// [RULE16] Overlapped data command with release interrupt enabled must release.
// [RULE17] Release: release set, direction and command clear, status bits clear.
// [RULE18] After release, ready device sets service flag, all else unchanged.
// [RULE19] Service command brings data transfer or completion content.
// [RULE20] Host loads the byte count limit before issuing the command.
// [RULE21] Host requests overlap through the features register bit.
// [RULE22] Completion: direction and command-or-data set, release clear.
// [RULE23] Host moves exactly the presented count, odd rounded up a word.
`timescale 1ns/100ps
`default_nettype none
module pcps_phase_engine #(
  parameter int LEN_W      = 24,
  parameter int PKT_WORDS  = pcps_pkg::PKT_WORDS_DEF,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                  mclk,           // 50 MHz clock
  input  wire logic                  rst,            // Sync reset
  input  wire logic [2:0]            tf_addr,        // Task file address
  input  wire logic                  tf_wr,          // Register write
  input  wire logic                  tf_rd,          // Register read
  input  wire logic [7:0]            tf_wdata,       // Register write data
  output logic [7:0]                 tf_rdata,       // Register read data
  input  wire logic                  dd_wr,          // Data word write
  input  wire logic [15:0]           dd_wdata,       // Data word in
  output logic                       dd_wr_ready,    // Data write takeable
  input  wire logic                  dd_rd,          // Data word read
  output logic                       dd_rd_ready,    // Data read takeable
  output logic [15:0]                dd_rdata,       // Data word out
  input  wire logic                  cfg_overlap_ok, // Overlap supported
  input  wire logic                  cfg_queue_ok,   // Queuing supported
  input  wire logic                  cfg_rel_irq_en, // Release irq enabled
  input  wire logic                  cfg_ovl_dma_ok, // Overlapped DMA ok
  input  wire logic                  be_cmd_ready,   // Other cmd queued
  input  wire logic                  be_plan_valid,  // Transfer plan pulse
  input  wire logic [LEN_W-1:0]      be_plan_len,    // Total bytes, 0 none
  input  wire logic                  be_plan_dir_in, // Device to host
  input  wire logic                  be_data_ready,  // Backend can move data
  input  wire logic                  be_finish,      // Command end pulse
  input  wire logic                  be_fail,        // End with error
  output logic                       be_pkt_taken,   // Packet done pulse
  output logic [15:0]                be_wdata,       // Word to backend
  output logic                       be_wpad,        // Upper byte is pad
  output logic                       be_wpkt,        // Word is packet
  output logic                       be_wvalid,      // Word valid
  input  wire logic                  be_wready,      // Backend takes word
  input  wire logic [15:0]           be_rdata,       // Word from backend
  input  wire logic                  be_rvalid,      // Read word valid
  output logic                       be_rready       // Read word taken
);
  import pcps_pkg::*;

  typedef struct packed {
    pcps_phase_t      ph;
    logic             bsy;
    logic             data_request_flag;
    logic             dma_ready_flag;
    logic             service_flag_rel;
    logic             chk;
    logic             release_flag;
    logic             io;
    logic             cd;
    logic [7:0]       feat;
    logic [TAG_W-1:0] tag;
    logic [7:0]       unit;
    logic [15:0]      limit;
    logic [15:0]      bcount;
    logic [LEN_W-1:0] rem;
    logic [15:0]      words;
    logic             dir_in;
    logic             last;
    logic             pkt_taken;
    logic [7:0]       rdata;
    logic [15:0]      ddr;
  } pcps_eng_t;

  pcps_eng_t s, n;

  logic [FIFO_W-1:0] fifo_in, fifo_out;
  logic              fifo_in_ready;
  logic              wr_open, wr_acc, rd_acc, go_done, cmd_wr;
  logic              service_flag_out, tag_on, final_pad;
  logic [TAG_W-1:0]  ir_tag;
  logic [7:0]        ireason, status, rd_mux;
  logic [15:0]       shown_bc, cnt_now, lim_eff;
  logic              cnt_final;

  // ------------------------------------------------------------------
  // Status and reason encoding
  // ------------------------------------------------------------------
  function automatic logic [7:0] status_byte(input pcps_eng_t e,
                                             input logic service_flag);
    logic [7:0] b;
    b = 8'h00;
    b[ST_BSY]  = e.bsy;
    b[ST_RDY]  = 1'b1;
    b[ST_DMA_READY_FLAG] = e.dma_ready_flag;
    b[ST_SERVICE_FLAG] = service_flag;
    b[ST_DRQ]  = e.data_request_flag;
    b[ST_CHK]  = e.chk;
    return b;
  endfunction : status_byte

  assign service_flag_out = s.service_flag_rel || be_cmd_ready;             // [RULE4]
  assign tag_on   = cfg_queue_ok && cfg_overlap_ok && s.feat[FT_OVL];
  assign ir_tag   = tag_on ? s.tag : '0;                    // [RULE5]
  assign ireason  = {ir_tag, s.release_flag, s.io, s.cd};
  assign status   = status_byte(s, service_flag_out);
  // Awaiting the packet the count registers echo the host limit
  assign shown_bc = (s.ph == PH_AWAIT) ? s.limit : s.bcount; // [RULE2]

  always_comb begin
    unique case (tf_addr)
      TF_DATA: rd_mux = 8'h00;
      TF_FEAT: rd_mux = s.chk ? ER_ABORT : 8'h00;
      TF_SCNT: rd_mux = ireason;
      TF_SNUM: rd_mux = 8'h00;
      TF_CLO:  rd_mux = shown_bc[7:0];
      TF_CHI:  rd_mux = shown_bc[15:8];
      TF_DEVH: rd_mux = s.unit;
      TF_CMD:  rd_mux = status;
    endcase
  end

  // ------------------------------------------------------------------
  // Data path
  // ------------------------------------------------------------------
  pcps_count_calc #(.LEN_W(LEN_W)) u_count (
    .limit     (s.limit),
    .remaining (s.rem),
    .lim_eff   (lim_eff),
    .count     (cnt_now),
    .final_req (cnt_final)
  );

  // Host writes only reach the FIFO after the packet or while it is due
  assign wr_open = (s.ph == PH_AWAIT) ||
                   ((s.ph == PH_DATA) && !s.dir_in);        // [RULE6]
  assign dd_wr_ready = wr_open && fifo_in_ready;
  assign wr_acc      = dd_wr && dd_wr_ready;
  assign dd_rd_ready = (s.ph == PH_DATA) && s.dir_in && be_rvalid;
  assign rd_acc      = dd_rd && dd_rd_ready;
  assign be_rready   = rd_acc;
  assign dd_rdata    = s.ddr;
  assign tf_rdata    = s.rdata;
  assign be_pkt_taken = s.pkt_taken;
  // Last word of an odd final count carries a pad in the upper byte
  assign final_pad = (s.ph == PH_DATA) && (s.words == 16'h0001) &&
                     s.bcount[0];                           // [RULE11]
  assign fifo_in   = {(s.ph == PH_AWAIT), final_pad, dd_wdata};
  assign cmd_wr    = tf_wr && (tf_addr == TF_CMD);

  pcps_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (wr_acc),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (be_wvalid),
    .out_ready (be_wready)
  );
  assign be_wdata = fifo_out[15:0];
  assign be_wpad  = fifo_out[FB_PAD];
  assign be_wpkt  = fifo_out[FB_PKT];

  // Error also ends a next or data phase; a normal end only the plan or final phase
  assign go_done = be_finish &&
                   ((s.ph == PH_FIN) || (s.ph == PH_PLAN) ||
                    (be_fail && ((s.ph == PH_NEXT) || (s.ph == PH_DATA))));

  // ------------------------------------------------------------------
  // Phase sequencing
  // ------------------------------------------------------------------
  always_comb begin
    n = s;
    n.pkt_taken = 1'b0;
    n.rdata = rd_mux;
    if (tf_wr) begin
      unique case (tf_addr)
        TF_FEAT: n.feat = tf_wdata;                         // [RULE21]
        TF_SCNT: n.tag = tf_wdata[SC_TAG_LSB +: TAG_W];
        TF_CLO:  n.limit[7:0] = tf_wdata;                   // [RULE20]
        TF_CHI:  n.limit[15:8] = tf_wdata;                  // [RULE20]
        TF_DEVH: n.unit = tf_wdata;
        TF_DATA, TF_SNUM, TF_CMD: begin
        end
      endcase
    end
    if (cmd_wr && (tf_wdata == CMD_PACKET) &&
        ((s.ph == PH_IDLE) || (s.ph == PH_DONE))) begin
      n.ph = PH_AWAIT;
      n.bsy = 1'b0;                                         // [RULE3]
      n.data_request_flag = 1'b1;                                         // [RULE3]
      n.dma_ready_flag = 1'b0;                                        // [RULE3]
      n.chk = 1'b0;                                         // [RULE3]
      n.cd = 1'b1;                                          // [RULE1]
      n.io = 1'b0;                                          // [RULE1]
      n.release_flag = 1'b0;                                         // [RULE1]
      n.words = 16'(PKT_WORDS);
    end
    if (cmd_wr && (tf_wdata == CMD_SERVICE) && (s.ph == PH_SRQ)) begin
      n.ph = PH_NEXT;                                       // [RULE19]
      n.bsy = 1'b1;
      n.release_flag = 1'b0;
      n.service_flag_rel = 1'b0;
    end
    unique case (s.ph)
      PH_IDLE, PH_DONE, PH_SRQ, PH_FIN: begin
      end
      PH_AWAIT: begin
        if (wr_acc) begin
          n.words = s.words - 16'h0001;
          if (s.words == 16'h0001) begin
            n.ph = PH_PLAN;
            n.bsy = 1'b1;                                   // [RULE14]
            n.data_request_flag = 1'b0;                                   // [RULE14]
            n.pkt_taken = 1'b1;
          end
        end
      end
      PH_PLAN: begin
        if (be_plan_valid && !be_finish) begin
          n.rem = be_plan_len;
          n.dir_in = be_plan_dir_in;
          if (be_plan_len == '0) begin
            n.ph = PH_FIN;
          end else if (s.feat[FT_OVL] && cfg_overlap_ok &&
                       (cfg_rel_irq_en || !be_data_ready)) begin
            n.ph = PH_REL;                                  // [RULE15] [RULE16]
            n.release_flag = 1'b1;                                   // [RULE17]
            n.io = 1'b0;                                    // [RULE17]
            n.cd = 1'b0;                                    // [RULE17]
            n.bsy = 1'b0;                                   // [RULE17]
            n.dma_ready_flag = 1'b0;                                  // [RULE17]
            n.data_request_flag = 1'b0;                                   // [RULE17]
            n.chk = 1'b0;                                   // [RULE17]
          end else begin
            n.ph = PH_NEXT;                                 // [RULE6]
          end
        end
      end
      PH_NEXT: begin
        if (be_data_ready) begin
          n.ph = PH_DATA;
          n.bcount = cnt_now;                               // [RULE7]
          n.last = cnt_final;
          // Words to move: count rounded up to whole words
          n.words = 16'((17'(cnt_now) + 17'h00001) >> 1);   // [RULE23]
          n.cd = 1'b0;                                      // [RULE12]
          n.release_flag = 1'b0;                                     // [RULE12]
          n.io = s.dir_in;                                  // [RULE12]
          n.bsy = 1'b0;                                     // [RULE13]
          n.data_request_flag = 1'b1;                                     // [RULE13]
          n.chk = 1'b0;                                     // [RULE13]
          n.dma_ready_flag = s.feat[FT_DMA] && cfg_ovl_dma_ok;        // [RULE13]
        end
      end
      PH_DATA: begin
        if (rd_acc) begin
          // Pad byte of an odd final word goes out as zero
          n.ddr = final_pad ? {8'h00, be_rdata[7:0]} : be_rdata; // [RULE11]
        end
        if (wr_acc || rd_acc) begin
          n.words = s.words - 16'h0001;
          if (s.words == 16'h0001) begin
            n.rem = s.rem - LEN_W'(s.bcount);
            n.ph = s.last ? PH_FIN : PH_NEXT;
            n.bsy = 1'b1;
            n.data_request_flag = 1'b0;
            n.dma_ready_flag = 1'b0;
          end
        end
      end
      PH_REL: begin
        // Only the service flag moves while the bus is released
        if (be_data_ready) begin
          n.service_flag_rel = 1'b1;                                // [RULE18]
          n.ph = PH_SRQ;
        end
      end
    endcase
    if (go_done) begin
      n.ph = PH_DONE;
      n.io = 1'b1;                                          // [RULE22]
      n.cd = 1'b1;                                          // [RULE22]
      n.release_flag = 1'b0;                                         // [RULE22]
      n.bsy = 1'b0;
      n.data_request_flag = 1'b0;
      n.dma_ready_flag = 1'b0;
      n.chk = be_fail;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence seq_pkt_last;
    (s.ph == PH_AWAIT) && wr_acc && (s.words == 16'h0001);
  endsequence

  sequence seq_busy_plan;
    s.bsy && !s.data_request_flag && (s.ph == PH_PLAN) && be_pkt_taken;
  endsequence

  sequence seq_forced_rel;
    (s.ph == PH_PLAN) && be_plan_valid && !be_finish &&
    (be_plan_len != '0) && s.feat[FT_OVL] && cfg_overlap_ok &&
    cfg_rel_irq_en;
  endsequence

  chk_await_reason: assert property ( // [RULE1]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_AWAIT) |-> (ireason[2:0] == 3'h1))
    else $error("await reason bits wrong");

  chk_await_count: assert property ( // [RULE2]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_AWAIT) && tf_rd && (tf_addr == TF_CHI)
      |=> (tf_rdata == $past(s.limit[15:8])))
    else $error("await count not the limit");

  chk_await_status: assert property ( // [RULE3]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_AWAIT) |-> (!status[ST_BSY] && status[ST_DRQ] &&
                            !status[ST_DMA_READY_FLAG] && !status[ST_CHK]))
    else $error("await status wrong");

  chk_service_flag_flag: assert property ( // [RULE4]
    @(posedge mclk) disable iff (rst)
    be_cmd_ready && tf_rd && (tf_addr == TF_CMD) |=> tf_rdata[ST_SERVICE_FLAG])
    else $error("service flag missing");

  chk_tag_gate: assert property ( // [RULE5]
    @(posedge mclk) disable iff (rst)
    !(cfg_queue_ok && cfg_overlap_ok) |-> (ireason[7:3] == '0))
    else $error("tag shown without overlap");

  chk_data_entry: assert property ( // [RULE6]
    @(posedge mclk) disable iff (rst)
    $rose(s.ph == PH_DATA) |-> ($past(s.ph) == PH_NEXT))
    else $error("data phase entered early");

  chk_count_legal: assert property ( // [RULE8] [RULE9]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_DATA) && (lim_eff > 16'h0001) |->
      (s.bcount != BC_ZERO) && (s.bcount <= BC_MAX) &&
      (s.bcount <= lim_eff))
    else $error("illegal byte count");

  chk_even_count: assert property ( // [RULE10]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_DATA) && !s.last |-> !s.bcount[0])
    else $error("odd count before last");

  chk_data_flags: assert property ( // [RULE12] [RULE13]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_DATA) |-> !s.cd && !s.release_flag && (s.io == s.dir_in) &&
                          !s.bsy && s.data_request_flag && !s.chk)
    else $error("data phase flags wrong");

  chk_pkt_taken: assert property ( // [RULE14]
    @(posedge mclk) disable iff (rst)
    seq_pkt_last |=> seq_busy_plan)
    else $error("busy not set after packet");

  chk_rel_forced: assert property ( // [RULE16]
    @(posedge mclk) disable iff (rst)
    seq_forced_rel |=> (s.ph == PH_REL) ##1 s.release_flag[*1])
    else $error("release not taken");

  chk_rel_flags: assert property ( // [RULE17]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_REL) |-> (ireason[2:0] == 3'h4) && !s.bsy && !s.dma_ready_flag &&
                         !s.data_request_flag && !s.chk)
    else $error("release flags wrong");

  chk_service_flag_hold: assert property ( // [RULE18]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_SRQ) && ($past(s.ph) == PH_REL) |->
      s.service_flag_rel && ({ireason, s.bsy, s.data_request_flag, s.dma_ready_flag, s.chk} ==
      $past({ireason, s.bsy, s.data_request_flag, s.dma_ready_flag, s.chk})))
    else $error("bits moved at service request");

  chk_service_cmd: assert property ( // [RULE19]
    @(posedge mclk) disable iff (rst)
    (s.ph == PH_SRQ) && cmd_wr && (tf_wdata == CMD_SERVICE)
      |=> (s.ph == PH_NEXT) && s.bsy && !s.service_flag_rel)
    else $error("service command ignored");

  chk_done_flags: assert property ( // [RULE22]
    @(posedge mclk) disable iff (rst)
    go_done |=> (ireason[2:0] == 3'h3) && !s.bsy && !s.data_request_flag &&
                (s.chk == $past(be_fail)))
    else $error("completion flags wrong");
endmodule : pcps_phase_engine
`default_nettype wire

// >>> pcps_pkg.sv
// Constants and types shared by the packet command phase engine
package pcps_pkg;
  // Task file register addresses
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_FEAT = 3'h1;
  localparam logic [2:0] TF_SCNT = 3'h2;
  localparam logic [2:0] TF_SNUM = 3'h3;
  localparam logic [2:0] TF_CLO  = 3'h4;
  localparam logic [2:0] TF_CHI  = 3'h5;
  localparam logic [2:0] TF_DEVH = 3'h6;
  localparam logic [2:0] TF_CMD  = 3'h7;
  // Command codes
  localparam logic [7:0] CMD_PACKET  = 8'hA0;
  localparam logic [7:0] CMD_SERVICE = 8'hA2;
  // Status bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DMA_READY_FLAG = 5;
  localparam int ST_SERVICE_FLAG = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_CHK  = 0;
  // Features and error bits
  localparam int FT_DMA = 0;
  localparam int FT_OVL = 1;
  localparam int SC_TAG_LSB = 3;
  localparam logic [7:0] ER_ABORT = 8'h04;
  // Byte count limits
  localparam logic [15:0] BC_MAX  = 16'hFFFE;
  localparam logic [15:0] BC_ONES = 16'hFFFF;
  localparam logic [15:0] BC_ZERO = 16'h0000;
  localparam logic [15:0] BC_MIN_EVEN = 16'h0002;
  // Write FIFO word layout: data, pad marker, packet marker
  localparam int FIFO_W = 18;
  localparam int FB_PAD = 16;
  localparam int FB_PKT = 17;
  localparam int TAG_W  = 5;
  localparam int PKT_WORDS_DEF = 6;

  typedef enum logic [3:0] {
    PH_IDLE, PH_AWAIT, PH_PLAN, PH_NEXT, PH_DATA,
    PH_FIN, PH_REL, PH_SRQ, PH_DONE
  } pcps_phase_t;
endpackage : pcps_pkg

// >>> pcps_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pcps_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 4
) (
  input  wire logic         mclk,      // Clock
  input  wire logic         rst,       // Sync reset
  input  wire logic [W-1:0] in_data,   // Fill data
  input  wire logic         in_valid,  // Fill valid
  output logic              in_ready,  // Not full
  output logic [W-1:0]      out_data,  // Head word
  output logic              out_valid, // Not empty
  input  wire logic         out_ready  // Drain ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } pcps_fifo_t;

  pcps_fifo_t s, n;
  logic push, pop;

  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp = bump(s.wp);
    end
    if (pop) begin
      n.rp = bump(s.rp);
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : pcps_fifo
`default_nettype wire

// >>> pcps_count_calc.sv
// Per-request byte count chooser for PIO data phases
`timescale 1ns/100ps
`default_nettype none
module pcps_count_calc
  import pcps_pkg::*;
#(
  parameter int LEN_W = 24
) (
  input  wire logic [15:0]      limit,     // Host byte count limit
  input  wire logic [LEN_W-1:0] remaining, // Bytes left in command
  output logic [15:0]           lim_eff,   // Limit as interpreted
  output logic [15:0]           count,     // Count for this request
  output logic                  final_req  // This request ends data
);
  always_comb begin
    // All ones and zero both fall back to the largest legal count
    lim_eff = ((limit == BC_ONES) || (limit == BC_ZERO)) ? BC_MAX : limit;
    final_req = (remaining <= LEN_W'(lim_eff));
    if (final_req) begin
      count = remaining[15:0];                        // [RULE10]
    end else begin
      count = {lim_eff[15:1], 1'b0};                  // [RULE8] [RULE9]
      // Odd limit of one with more to move cannot be honoured evenly
      if (count == BC_ZERO) begin
        count = BC_MIN_EVEN;
      end
    end
  end
endmodule : pcps_count_calc
`default_nettype wire

// >>> pcps_host_model.sv
// Host adapter model: task file and data word port
`timescale 1ns/100ps
`default_nettype none
module pcps_host_model (
  input  wire logic        mclk,        // Clock
  output logic [2:0]       tf_addr,     // Register address
  output logic             tf_wr,       // Register write
  output logic             tf_rd,       // Register read
  output logic [7:0]       tf_wdata,    // Write data
  input  wire logic [7:0]  tf_rdata,    // Read data
  output logic             dd_wr,       // Word write
  output logic [15:0]      dd_wdata,    // Word out
  input  wire logic        dd_wr_ready, // Write takeable
  output logic             dd_rd,       // Word read
  input  wire logic        dd_rd_ready, // Read takeable
  input  wire logic [15:0] dd_rdata     // Word in
);
  initial begin
    {tf_addr, tf_wr, tf_rd, tf_wdata, dd_wr, dd_rd} = '0;
    dd_wdata = 16'hFFFF;
  end
  // Limit and features go in before the command
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    tf_addr = a;
    tf_wdata = d;
    tf_wr = 1'b1;
    @(negedge mclk);
    tf_wr = 1'b0;
    tf_wdata = ~d;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] q);
    @(negedge mclk);
    tf_addr = a;
    tf_rd = 1'b1;
    @(negedge mclk);
    q = tf_rdata;
    tf_rd = 1'b0;
  endtask : reg_rd
  // Request held until the edge that takes it; the wait for ready gives up after 60 cycles
  task automatic word_io(input logic wr, input logic [15:0] d,
                         output logic [15:0] q);
    int n;
    n = 0;
    @(negedge mclk);
    dd_wr = wr;
    dd_rd = !wr;
    dd_wdata = d;
    #1;
    while (!(wr ? dd_wr_ready : dd_rd_ready) && n < 60) begin
      @(negedge mclk);
      #1;
      n++;
    end
    @(negedge mclk);
    q = dd_rdata;
    dd_wr = 1'b0;
    dd_rd = 1'b0;
    dd_wdata = ~d;
  endtask : word_io
endmodule : pcps_host_model
`default_nettype wire

// >>> tb.sv
// Testbench for the packet command phase engine
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, v) begin cmp_count++; if ((v) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, v); end end
module tb;
  import pcps_pkg::*;
  logic mclk = 0, rst = 1, cfg_overlap_ok = 0, cfg_queue_ok = 0;
  logic cfg_rel_irq_en = 0, cfg_ovl_dma_ok = 0, be_cmd_ready = 0;
  logic be_plan_valid = 0, be_plan_dir_in = 1, be_data_ready = 1;
  logic be_finish = 0, be_fail = 0, be_wready = 1, be_rvalid = 1;
  logic be_rready, tf_wr, tf_rd, dd_wr, dd_rd, dd_wr_ready, dd_rd_ready;
  logic be_pkt_taken, be_wpad, be_wpkt, be_wvalid;
  logic [23:0] be_plan_len = '0;
  logic [15:0] be_rdata = 16'hC3A5, dd_wdata, dd_rdata, q, be_wdata;
  logic [7:0]  tf_wdata, tf_rdata;
  logic [2:0]  tf_addr;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n_pkt = 0, n_pad = 0;
  pcps_phase_engine i_dut (.mclk, .rst, .tf_addr, .tf_wr, .tf_rd, .tf_wdata,
    .tf_rdata, .dd_wr, .dd_wdata, .dd_wr_ready, .dd_rd, .dd_rd_ready,
    .dd_rdata, .cfg_overlap_ok, .cfg_queue_ok, .cfg_rel_irq_en,
    .cfg_ovl_dma_ok, .be_cmd_ready, .be_plan_valid, .be_plan_len,
    .be_plan_dir_in, .be_data_ready, .be_finish, .be_fail, .be_pkt_taken,
    .be_wdata, .be_wpad, .be_wpkt, .be_wvalid, .be_wready,
    .be_rdata, .be_rvalid, .be_rready);
  pcps_host_model i_host (.mclk, .tf_addr, .tf_wr, .tf_rd, .tf_wdata,
    .tf_rdata, .dd_wr, .dd_wdata, .dd_wr_ready, .dd_rd, .dd_rd_ready,
    .dd_rdata);
  initial forever #10 mclk = ~mclk;
  // Backend side: packet words, done pulses weigh 16, pad-marked words
  always @(posedge mclk) begin
    if (be_wvalid && be_wpkt && be_wdata == 16'h1234) n_pkt++;
    if (be_pkt_taken) n_pkt += 16;
    if (be_wvalid && !be_wpkt && be_wpad) n_pad++;
  end
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.reg_rd(a, v);
    `CHK("task file", e, v)
  endtask : chk_reg
  // Limit 4, six packet words, then a five-byte plan; tg is the shown tag
  task automatic start_cmd(input logic [7:0] feat, input logic [7:0] tg);
    int b;
    b = n_pkt;
    i_host.reg_wr(TF_FEAT, feat);
    i_host.reg_wr(TF_CLO, 8'h04);
    i_host.reg_wr(TF_CHI, 8'h00);
    i_host.reg_wr(TF_CMD, CMD_PACKET);
    chk_reg(TF_CMD, 8'h48);
    chk_reg(TF_SCNT, tg | 8'h01);
    chk_reg(TF_CLO, 8'h04);
    chk_reg(TF_CHI, 8'h00);
    repeat (6) i_host.word_io(1'b1, 16'h1234, q);
    chk_reg(TF_CMD, 8'hC0);
    `CHK("packet words", 32'h16, n_pkt - b)
    @(negedge mclk) {be_plan_valid, be_plan_len} = {1'b1, 24'h5};
    @(negedge mclk) be_plan_valid = 1'b0;
  endtask : start_cmd
  // Requests of 4 then 1 byte, the last one padded; data-out ends in error
  task automatic data_in_finish(input logic [7:0] tg, input logic din,
                                input logic [7:0] st);
    chk_reg(TF_CMD, st);
    chk_reg(TF_SCNT, tg | {6'h00, din, 1'b0});
    chk_reg(TF_CLO, 8'h04);
    repeat (2) i_host.word_io(!din, 16'h5A5A, q);
    if (din) `CHK("data word", 16'hC3A5, q)
    chk_reg(TF_CLO, 8'h01);
    i_host.word_io(!din, 16'h5A5A, q);
    @(negedge mclk) {be_finish, be_fail} = {1'b1, !din};
    @(negedge mclk) {be_finish, be_fail} = 2'h0;
    if (din) `CHK("data word", 16'h00A5, q)
    else `CHK("pad words", 1, n_pad)
    chk_reg(TF_SCNT, tg | 8'h03);
    chk_reg(TF_CMD, {7'h20, !din});
  endtask : data_in_finish
  task automatic t_release();
    {cfg_overlap_ok, cfg_queue_ok, cfg_rel_irq_en, cfg_ovl_dma_ok} = 4'hF;
    {be_data_ready, be_plan_dir_in} = 2'h0;
    start_cmd(8'h03, 8'h28);
    chk_reg(TF_SCNT, 8'h2C);
    chk_reg(TF_CMD, 8'h40);
    be_data_ready = 1'b1;
    chk_reg(TF_CMD, 8'h50);
    chk_reg(TF_SCNT, 8'h2C);
    i_host.reg_wr(TF_CMD, CMD_SERVICE);
    data_in_finish(8'h28, 1'b0, 8'h68);
  endtask : t_release
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    // Tag stays loaded; it may only show with queuing and overlap
    i_host.reg_wr(TF_SCNT, 8'h28);
    start_cmd(8'h00, 8'h00);
    data_in_finish(8'h00, 1'b1, 8'h48);
    be_cmd_ready = 1'b1;
    chk_reg(TF_CMD, 8'h50);
    be_cmd_ready = 1'b0;
    t_release();
    close_out();
  end
endmodule : tb
`default_nettype wire
